// ---- hdl/acsr_pkg.sv ----
package acsr_pkg;
  localparam int RES_W = 10;
  localparam int SEL_W = 5;
  localparam int REF_W = 2;
  localparam int PRESC_DIV = 4;
  localparam int NORMAL_CYCLES = 13;
  localparam int FIRST_CYCLES = 25;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;
  localparam logic [4:0] SEL_RESET = 5'h00;
  localparam logic [1:0] REF_RESET = 2'h0;
  localparam logic [4:0] DIFF_FIRST = 5'h08;
  localparam logic [4:0] DIFF_LAST = 5'h1D;
  typedef struct packed {
    logic [REF_W-1:0] ref_sel;
    logic [SEL_W-1:0] chan_sel;
  } acsr_sel_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } acsr_result_t;
endpackage : acsr_pkg

// ---- hdl/acsr_presenter.sv ----
`timescale 1ns/1ns
`default_nettype none
module acsr_presenter (
  // Stored result and alignment
  input wire logic [9:0] result,
  input wire logic left_adjust_select,
  // Register pair
  output acsr_pkg::acsr_result_t pair
);
  always_comb begin
    if (left_adjust_select) begin
      pair.high = result[9:2]; // RULE19 RULE16
      pair.low = {result[1:0], 6'h00};
    end else begin
      pair.high = {6'h00, result[9:8]}; // RULE19
      pair.low = result[7:0];
    end
  end
endmodule : acsr_presenter
`default_nettype wire

// ---- hdl/acsr_ctrl.sv ----
// Overview of operation
// RULE1: Software picks the channel before a single conversion, changes it later.
// RULE2: In free running, software picks the channel before the first conversion.
// RULE3: Free-running change after completion affects only later conversions.
// RULE4: Software should discard the first result after a differential gain switch.
// RULE5: Single-ended input above reference gives a code at or near full scale.
// RULE6: Software should discard the first result after a reference change.
// RULE7: Sleep entry with enabled idle converter starts a conversion once halted; code also needs single mode and done_irq_enable.
// RULE8: A sleep conversion raises its completion request even if woken early.
// RULE9: After such a wake-up the CPU stays active until a new sleep command; code keeps cpu_stay_active through one that starts a sleep conversion.
// RULE10: Other sleep modes leave the converter enabled.
// RULE11: Software may toggle enable after waking for a valid differential result.
// RULE12: Converter pins used as digital outputs must not toggle mid-conversion.
// RULE13: Result is in the register pair once the done flag is set.
// RULE14: Single-ended code is unsigned ten bits, input times 1023 over reference.
// RULE15: Differential code is two's complement ten bits, 0x200 through 0x1FF.
// RULE16: Differential result top bit in the high byte is the sign.
// RULE17: Selection tracks writes until start, locks, resumes in final cycle.
// RULE18: Changing left adjust changes the pair presentation immediately.
// RULE19: Left adjust puts bits 9..2 high; right adjust puts bits 7..0 low.
`timescale 1ns/1ns
`default_nettype none
module acsr_ctrl #(
  parameter int PRESC = acsr_pkg::PRESC_DIV
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Software control
  input wire logic converter_enable_bit,
  input wire logic start_write,
  input wire logic free_running,
  input wire logic done_irq_enable,
  input wire logic done_flag_clear,
  input wire logic left_adjust_select,
  input wire acsr_pkg::acsr_sel_t input_select_register,
  // Sleep control
  input wire logic sleep_cmd,
  input wire logic sleep_noise_or_idle,
  input wire logic cpu_halted,
  input wire logic other_wake,
  // Analog core
  input wire logic [9:0] sar_code,
  // Status
  output logic start_conversion_bit,
  output logic conversion_done_flag,
  output logic done_irq,
  output logic cpu_stay_active,
  output acsr_pkg::acsr_sel_t active_select,
  output acsr_pkg::acsr_result_t result_pair,
  output logic result_sign_bit
);
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} acsr_state_t;
  acsr_state_t state_reg;
  logic [7:0] presc_reg;
  logic [4:0] cyc_reg;
  logic first_reg;
  logic sleep_arm_reg;
  logic [9:0] result_reg;
  logic tick;
  logic last_cycle;
  logic done_evt;
  logic sleep_start;

  assign tick = converter_enable_bit && (presc_reg == 8'(PRESC - 1));
  assign last_cycle = (state_reg == ST_CONV) && tick &&
    (cyc_reg == (first_reg ? 5'(acsr_pkg::FIRST_CYCLES - 1) : 5'(acsr_pkg::NORMAL_CYCLES - 1)));
  assign done_evt = last_cycle;
  // RULE7
  assign sleep_start = sleep_cmd && sleep_noise_or_idle && cpu_halted && converter_enable_bit &&
    (state_reg == ST_IDLE) && !free_running && done_irq_enable;

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !converter_enable_bit) begin
      presc_reg <= 8'h00;
    end else if (tick) begin
      presc_reg <= 8'h00;
    end else begin
      presc_reg <= presc_reg + 8'h01;
    end
  end

  // Disable aborts; RULE10: sleep mode never touches the enable
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !converter_enable_bit) begin
      state_reg <= ST_IDLE;
      cyc_reg <= 5'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_write || sleep_start) begin
            state_reg <= ST_ARMED;
          end
        end
        ST_ARMED: begin
          if (tick) begin
            state_reg <= ST_CONV;
            cyc_reg <= 5'h00;
          end
        end
        ST_CONV: begin
          if (last_cycle) begin
            // RULE3: restart with selection captured at the new start edge
            state_reg <= free_running ? ST_CONV : ST_IDLE;
            cyc_reg <= 5'h00;
          end else if (tick) begin
            cyc_reg <= cyc_reg + 5'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Extended first conversion after enabling; RULE11
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !converter_enable_bit) begin
      first_reg <= 1'b1;
    end else if (last_cycle) begin
      first_reg <= 1'b0;
    end
  end

  // Selection follows writes except while locked mid-conversion
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      active_select <= '{ref_sel: acsr_pkg::REF_RESET, chan_sel: acsr_pkg::SEL_RESET};
    end else if (state_reg != ST_CONV || last_cycle) begin
      active_select <= input_select_register; // RULE17 RULE3
    end
  end

  // Code arrives already in unsigned or two's-complement form from the core
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      result_reg <= 10'h000;
    end else if (done_evt) begin
      result_reg <= sar_code; // RULE13 RULE14 RULE15 RULE5
    end
  end

  // Set wins over clear
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conversion_done_flag <= 1'b0;
    end else if (done_evt) begin
      conversion_done_flag <= 1'b1; // RULE13
    end else if (done_flag_clear) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // Sleep conversion tracking; request stays valid after an early wake
  always_ff @(posedge ref_clk) begin
    if (!reset_n || !converter_enable_bit) begin
      sleep_arm_reg <= 1'b0;
    end else if (sleep_start) begin
      sleep_arm_reg <= 1'b1;
    end else if (done_evt) begin
      sleep_arm_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cpu_stay_active <= 1'b0;
    end else if (sleep_cmd && !sleep_start) begin
      cpu_stay_active <= 1'b0;
    end else if (sleep_arm_reg && (done_evt || other_wake)) begin
      cpu_stay_active <= 1'b1; // RULE9
    end
  end

  assign done_irq = conversion_done_flag && done_irq_enable; // RULE8
  assign start_conversion_bit = (state_reg != ST_IDLE);
  assign result_sign_bit = result_reg[9]; // RULE16

  acsr_presenter u_pres (
    .result(result_reg),
    .left_adjust_select(left_adjust_select), // RULE18
    .pair(result_pair)
  );

  property p_lock;
    @(posedge ref_clk) disable iff (!reset_n)
      (state_reg == ST_CONV && !last_cycle) |=> $stable(active_select);
  endproperty
  a_lock: assert property (p_lock) else $error("selection changed mid-conversion"); // RULE17

  property p_done;
    @(posedge ref_clk) disable iff (!reset_n)
      done_evt |=> conversion_done_flag && result_reg == $past(sar_code);
  endproperty
  a_done: assert property (p_done) else $error("result not stored with flag"); // RULE13

  property p_sleep;
    @(posedge ref_clk) disable iff (!reset_n)
      sleep_start |=> start_conversion_bit;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not start conversion"); // RULE7

  property p_irq;
    @(posedge ref_clk) disable iff (!reset_n)
      (done_evt && done_irq_enable && !done_flag_clear) |=> done_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("missing completion request"); // RULE8

  property p_free;
    @(posedge ref_clk) disable iff (!reset_n)
      (last_cycle && free_running && converter_enable_bit) |=> state_reg == ST_CONV;
  endproperty
  a_free: assert property (p_free) else $error("free run did not restart"); // RULE3

  property p_sign;
    @(posedge ref_clk) disable iff (!reset_n)
      left_adjust_select |-> result_pair.high[7] == result_sign_bit;
  endproperty
  a_sign: assert property (p_sign) else $error("sign bit misplaced"); // RULE16

  property p_align;
    @(posedge ref_clk) disable iff (!reset_n)
      !left_adjust_select |-> {result_pair.high[1:0], result_pair.low} == result_reg;
  endproperty
  a_align: assert property (p_align) else $error("right alignment wrong"); // RULE19

  property p_stay;
    @(posedge ref_clk) disable iff (!reset_n)
      (cpu_stay_active && !sleep_cmd) |=> cpu_stay_active;
  endproperty
  a_stay: assert property (p_stay) else $error("cpu active dropped early"); // RULE9
endmodule : acsr_ctrl
`default_nettype wire

// ---- sim/acsr_analog_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module acsr_analog_model (
  // Selection seen by the core
  input wire acsr_pkg::acsr_sel_t active_select,
  // Code toward the converter
  output logic [9:0] sar_code
);
  // Code mirrors channel and reference, so a stale latch shows
  // Analog pins are only read here, never driven as digital outputs
  assign sar_code = {active_select.chan_sel,
                     active_select.chan_sel ^ {3'h0, active_select.ref_sel}};
endmodule : acsr_analog_model
`default_nettype wire

// ---- sim/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic en = 1'b1, start_write = 1'b0, free_running = 1'b0, irq_en = 1'b0;
  logic clr = 1'b0, left = 1'b0, sleep_cmd = 1'b0, noise = 1'b0, halted = 1'b0;
  logic other_wake = 1'b0;
  logic [6:0] sel = 7'h00;
  logic [9:0] sar_code;
  logic busy, flag, irq, stay, sign;
  acsr_pkg::acsr_sel_t act;
  acsr_pkg::acsr_result_t pair;
  int err_total = 0;
  int checks = 0;
  logic hung = 1'b0;
  always #20 ref_clk = ~ref_clk;
  acsr_ctrl #(.PRESC(acsr_pkg::PRESC_DIV)) u_acsr_ctrl (.ref_clk(ref_clk),
    .reset_n(reset_n), .converter_enable_bit(en), .start_write(start_write),
    .free_running(free_running), .done_irq_enable(irq_en), .done_flag_clear(clr),
    .left_adjust_select(left), .input_select_register(sel), .sleep_cmd(sleep_cmd),
    .sleep_noise_or_idle(noise), .cpu_halted(halted), .other_wake(other_wake),
    .sar_code(sar_code), .start_conversion_bit(busy), .conversion_done_flag(flag),
    .done_irq(irq), .cpu_stay_active(stay), .active_select(act), .result_pair(pair),
    .result_sign_bit(sign));
  acsr_analog_model u_acsr_analog_model (.active_select(act), .sar_code(sar_code));
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // After a hang the remaining waits fall straight through to the report
  task automatic wait_done;
    int i;
    for (i = 0; i < 400 && flag !== 1'b1 && !hung; i++) begin
      tick(1);
    end
    if (i == 400) begin
      hung = 1'b1;
      err_total++;
      $display("wrong value done_flag expected %h seen %h", 1'b1, flag);
    end
  endtask : wait_done
  // Selection settles a cycle before the start request
  task automatic start(input logic [6:0] s);
    @(posedge ref_clk);
    sel <= s;
    @(posedge ref_clk);
    start_write <= 1'b1;
    @(posedge ref_clk);
    start_write <= 1'b0;
  endtask : start
  task automatic clear;
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    #1;
  endtask : clear
  function automatic logic [15:0] code(input logic [6:0] s);
    return {6'h00, s[4:0], s[4:0] ^ {3'h0, s[6:5]}};
  endfunction : code
  initial begin
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    start(7'h1F);
    wait_done();
    chk("pair_right", {6'h00, acsr_pkg::FULL_SCALE}, pair);
    chk("busy_end", 16'h0000, {15'h0, busy});
    @(posedge ref_clk);
    left <= 1'b1;
    #1;
    chk("pair_left", 16'hFFC0, pair);
    clear();
    @(posedge ref_clk);
    left <= 1'b0;
    // First result after a reference and gain channel change is thrown away
    start(7'h70);
    wait_done();
    clear();
    start(7'h70);
    wait_done();
    chk("pair_diff", code(7'h70), pair);
    chk("sign", 16'h0001, {15'h0, sign});
    chk("irq_masked", 16'h0000, {15'h0, irq});
    clear();
    start(7'h03);
    tick(8);
    @(posedge ref_clk);
    sel <= 7'h25;
    tick(8);
    chk("locked_sel", 16'h0003, {9'h0, act});
    @(posedge ref_clk);
    left <= 1'b1;
    #1;
    chk("busy_mid", 16'h0001, {15'h0, busy});
    chk("pair_left_mid", 16'h84C0, pair);
    @(posedge ref_clk);
    left <= 1'b0;
    wait_done();
    chk("locked_res", code(7'h03), pair);
    tick(1);
    chk("tracking", 16'h0025, {9'h0, act});
    clear();
    @(posedge ref_clk);
    free_running <= 1'b1;
    start(7'h02);
    wait_done();
    @(posedge ref_clk);
    sel <= 7'h04;
    clear();
    wait_done();
    chk("free_prev", code(7'h02), pair);
    clear();
    wait_done();
    chk("free_new", code(7'h04), pair);
    @(posedge ref_clk);
    free_running <= 1'b0;
    en <= 1'b0;
    tick(2);
    @(posedge ref_clk);
    en <= 1'b1;
    clear();
    // Sleep start needs irq enabled and single mode
    @(posedge ref_clk);
    irq_en <= 1'b1;
    noise <= 1'b1;
    halted <= 1'b1;
    sleep_cmd <= 1'b1;
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
    tick(2);
    chk("sleep_start", 16'h0001, {15'h0, busy});
    @(posedge ref_clk);
    other_wake <= 1'b1;
    halted <= 1'b0;
    @(posedge ref_clk);
    other_wake <= 1'b0;
    wait_done();
    chk("sleep_irq", 16'h0001, {15'h0, irq});
    clear();
    tick(10);
    chk("stay_active", 16'h0001, {15'h0, stay});
    // Other sleep mode held on while a conversion is run by hand
    @(posedge ref_clk);
    noise <= 1'b0;
    halted <= 1'b1;
    sleep_cmd <= 1'b1;
    tick(2);
    chk("stay_cleared", 16'h0000, {15'h0, stay});
    chk("no_auto_start", 16'h0000, {15'h0, busy});
    start(7'h01);
    wait_done();
    chk("other_sleep", code(7'h01), pair);
    @(posedge ref_clk);
    sleep_cmd <= 1'b0;
    close_out();
  end
endmodule : tb_top
`default_nettype wire
